// ### hw/ext_bus_pkg.sv
// constants, enumerations and carriers for the external memory bus interface
// assumes one core clock at 50 MHz and a core that issues one access at a time
package ext_bus_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned MCYC_CLOCKS     = 4;
	localparam int unsigned RESET_MCYCLES   = 2;
	localparam int unsigned RESET_CLOCKS    = RESET_MCYCLES * MCYC_CLOCKS;
	localparam int unsigned DATA_MCYC_MIN   = 2;
	localparam int unsigned DATA_MCYC_MAX   = 9;

	// ----------------------------------------------------------------
	// widths, addresses and reset values
	// ----------------------------------------------------------------
	localparam int unsigned STRETCH_W       = 3;
	localparam int unsigned MCOUNT_W        = 4;
	localparam int unsigned RSTCNT_W        = 4;
	localparam logic [15:0] INT_CODE_LIMIT  = 16'h8000;
	localparam logic [1:0]  PHASE_ADDR      = 2'h0;
	localparam logic [1:0]  PHASE_HOLD      = 2'h1;
	localparam logic [1:0]  PHASE_LAST      = 2'h3;
	localparam logic [7:0]  BYTE_RESET      = 8'h00;
	localparam logic [MCOUNT_W-1:0] FETCH_MCOUNT = 4'h1;
	localparam logic [RSTCNT_W-1:0] RSTCNT_DONE  = 4'h8;

	typedef enum logic [1:0] {
		ACC_FETCH      = 2'h0,
		ACC_CODE_TABLE = 2'h1,
		ACC_DATA_READ  = 2'h2,
		ACC_DATA_WRITE = 2'h3
	} access_kind_t;

	// gray codes along idle -> address -> strobe
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ADDR   = 2'b01,
		ST_STROBE = 2'b11
	} bus_state_t;

	typedef struct packed {
		access_kind_t kind;
		logic [15:0]  addr;
		logic [7:0]   wdata;
	} req_t;

endpackage

// ### hw/ext_bus_if.sv
// external program and data memory bus interface, device end
// assumes the core offers one access per machine cycle and an external
// transparent latch on the low address byte
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// pin synchroniser: three flops, change taken when last two agree
// ----------------------------------------------------------------
module pin_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_out  <= '0;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_out <= s3_reg;
			end
		end
	end
endmodule

module ext_bus_if (
	input  wire logic                  mclk_in,
	input  wire logic                  rstn_in,
	// core side
	input  wire ext_bus_pkg::req_t     req_in,
	input  wire logic                  req_valid_in,
	input  wire logic [2:0]            stretch_in,
	input  wire logic                  wait_enable_in,
	output logic                       req_ready_out,
	output logic                       rsp_valid_out,
	output logic                       rsp_external_out,
	output logic [7:0]                 rsp_rdata_out,
	output logic                       core_reset_out,
	// pins
	input  wire logic                  external_fetch_select_n_in,
	input  wire logic                  reset_pin_in,
	input  wire logic                  wait_pin_in,
	input  wire logic [7:0]            ad_in,
	output logic [7:0]                 ad_out,
	output logic                       ad_oe_out,
	output logic [7:0]                 addr_hi_out,
	output logic                       addr_latch_strobe_out,
	output logic                       program_fetch_strobe_n_out,
	output logic                       data_write_strobe_n_out,
	output logic                       data_read_strobe_n_out
);

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	logic [7:0] ad_s;
	logic [2:0] ctl_s;
	logic       fsel_n_s;
	logic       rst_pin_s;
	logic       wait_s;

	pin_sync3 #(.W(8)) u_sync_ad (
		.clk_in   (mclk_in),
		.rst_n_in (rst_n),
		.d_in     (ad_in),
		.q_out    (ad_s)
	);

	// wait pin is only ever sampled; this block has no driver for it
	pin_sync3 #(.W(3)) u_sync_ctl (
		.clk_in   (mclk_in),
		.rst_n_in (rst_n),
		.d_in     ({external_fetch_select_n_in, reset_pin_in, wait_pin_in}),
		.q_out    (ctl_s)
	);

	assign fsel_n_s  = ctl_s[2];
	assign rst_pin_s = ctl_s[1];
	assign wait_s    = ctl_s[0];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ext_bus_pkg::bus_state_t          state;
		logic [1:0]                       phase;
		logic [ext_bus_pkg::MCOUNT_W-1:0] mcount;
		logic [ext_bus_pkg::RSTCNT_W-1:0] rst_cnt;
		logic [2:0]                       stretch;
		logic                             extended;
		ext_bus_pkg::req_t                req;
		logic                             ready;
		logic                             rsp_valid;
		logic                             rsp_ext;
		logic [7:0]                       rdata;
		logic                             core_reset;
		logic [7:0]                       ad;
		logic                             ad_oe;
		logic [7:0]                       a_hi;
		logic                             ale;
		logic                             pfs_n;
		logic                             wr_n;
		logic                             rd_n;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic   internal;
	logic   is_code;

	always_comb begin
		s_next           = s_reg;
		s_next.rsp_valid = 1'b0;
		s_next.phase     = s_reg.phase + 2'h1;
		is_code          = (req_in.kind == ext_bus_pkg::ACC_FETCH) ||
		                   (req_in.kind == ext_bus_pkg::ACC_CODE_TABLE);
		// select high keeps the low code range internal
		internal         = is_code && fsel_n_s && (req_in.addr < ext_bus_pkg::INT_CODE_LIMIT);

		// pin must stay high two whole machine cycles
		if (!rst_pin_s) begin
			s_next.rst_cnt = '0;
		end else if (s_reg.rst_cnt != ext_bus_pkg::RSTCNT_DONE) begin
			s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
		end
		s_next.core_reset = (s_next.rst_cnt == ext_bus_pkg::RSTCNT_DONE);

		case (s_reg.state)
			ext_bus_pkg::ST_IDLE: begin
				if (req_valid_in && s_reg.ready) begin
					s_next.req      = req_in;
					s_next.extended = 1'b0;
					if (internal) begin
						// served inside: bus and strobes untouched
						s_next.rsp_valid = 1'b1;
						s_next.rsp_ext   = 1'b0;
						s_next.rdata     = ext_bus_pkg::BYTE_RESET;
					end else begin
						s_next.state   = ext_bus_pkg::ST_ADDR;
						s_next.ale     = 1'b1;
						s_next.ad      = req_in.addr[7:0];
						s_next.ad_oe   = 1'b1;
						s_next.a_hi    = req_in.addr[15:8];
						s_next.stretch = is_code ? 3'h0 : stretch_in;
						// data moves run 2 + stretch machine cycles
						s_next.mcount  = is_code ? ext_bus_pkg::FETCH_MCOUNT
						                         : ext_bus_pkg::FETCH_MCOUNT + {1'b0, stretch_in};
					end
				end
			end
			ext_bus_pkg::ST_ADDR: begin
				if (s_reg.phase == ext_bus_pkg::PHASE_ADDR) begin
					// latch closes here and keeps the low address
					s_next.ale = 1'b0;
				end else if (s_reg.phase == ext_bus_pkg::PHASE_HOLD) begin
					s_next.state = ext_bus_pkg::ST_STROBE;
					case (s_reg.req.kind)
						ext_bus_pkg::ACC_DATA_WRITE: begin
							s_next.wr_n = 1'b0;
							s_next.ad   = s_reg.req.wdata;
						end
						ext_bus_pkg::ACC_DATA_READ: begin
							s_next.rd_n  = 1'b0;
							s_next.ad_oe = 1'b0;
						end
						default: begin
							s_next.pfs_n  = 1'b0;
							s_next.ad_oe  = 1'b0;
						end
					endcase
				end
			end
			ext_bus_pkg::ST_STROBE: begin
				if (s_reg.phase == ext_bus_pkg::PHASE_LAST) begin
					if (s_reg.mcount != '0) begin
						s_next.mcount = s_reg.mcount - 4'h1;
					end else if (wait_enable_in && wait_s) begin
						s_next.extended = 1'b1;
					end else begin
						s_next.state     = ext_bus_pkg::ST_IDLE;
						s_next.pfs_n     = 1'b1;
						s_next.wr_n      = 1'b1;
						s_next.rd_n      = 1'b1;
						s_next.ad_oe     = 1'b0;
						s_next.rsp_valid = 1'b1;
						s_next.rsp_ext   = 1'b1;
						// read data lags the pins by the synchroniser depth
						s_next.rdata     = (s_reg.req.kind == ext_bus_pkg::ACC_DATA_WRITE)
						                   ? ext_bus_pkg::BYTE_RESET : ad_s;
					end
				end
			end
			default: begin
				s_next.state = ext_bus_pkg::ST_IDLE;
			end
		endcase

		// a pin reset aborts any access with the bus released
		if (s_next.core_reset) begin
			s_next.state     = ext_bus_pkg::ST_IDLE;
			s_next.ale       = 1'b0;
			s_next.pfs_n     = 1'b1;
			s_next.wr_n      = 1'b1;
			s_next.rd_n      = 1'b1;
			s_next.ad_oe     = 1'b0;
			s_next.rsp_valid = 1'b0;
		end
		// requests only start on a machine cycle boundary
		s_next.ready = (s_next.state == ext_bus_pkg::ST_IDLE) &&
		               (s_next.phase == ext_bus_pkg::PHASE_LAST) && !s_next.core_reset;
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_reg        <= '0;
			s_reg.pfs_n  <= 1'b1;
			s_reg.wr_n   <= 1'b1;
			s_reg.rd_n   <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign req_ready_out              = s_reg.ready;
	assign rsp_valid_out              = s_reg.rsp_valid;
	assign rsp_external_out           = s_reg.rsp_ext;
	assign rsp_rdata_out              = s_reg.rdata;
	assign core_reset_out             = s_reg.core_reset;
	assign ad_out                     = s_reg.ad;
	assign ad_oe_out                  = s_reg.ad_oe;
	assign addr_hi_out                = s_reg.a_hi;
	assign addr_latch_strobe_out      = s_reg.ale;
	assign program_fetch_strobe_n_out = s_reg.pfs_n;
	assign data_write_strobe_n_out    = s_reg.wr_n;
	assign data_read_strobe_n_out     = s_reg.rd_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n);

	logic [5:0] slen_reg;
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			slen_reg <= '0;
		end else if (!s_reg.wr_n || !s_reg.rd_n) begin
			slen_reg <= slen_reg + 6'h1;
		end else begin
			slen_reg <= '0;
		end
	end

	sequence take_s;
		req_valid_in && req_ready_out && s_reg.state == ext_bus_pkg::ST_IDLE;
	endsequence
	sequence data_end_s;
		$rose(data_write_strobe_n_out && data_read_strobe_n_out) && !s_reg.extended && !core_reset_out;
	endsequence

	ale_phase_a: assert property (addr_latch_strobe_out |-> s_reg.phase == 2'h0 && ad_oe_out)
		else $error("latch strobe outside address phase");
	int_fetch_quiet_a: assert property (take_s and internal |=> program_fetch_strobe_n_out [*4])
		else $error("program strobe on internal fetch");
	ext_fetch_forced_a: assert property (take_s and is_code and !fsel_n_s |=> s_reg.state == ext_bus_pkg::ST_ADDR)
		else $error("fetch not external with select low");
	program_fetch_strobe_n_kind_a: assert property (!program_fetch_strobe_n_out |-> !ad_oe_out &&
		(s_reg.req.kind == ext_bus_pkg::ACC_FETCH || s_reg.req.kind == ext_bus_pkg::ACC_CODE_TABLE))
		else $error("program strobe on wrong access");
	wr_drive_a: assert property (!data_write_strobe_n_out |-> ad_oe_out && ad_out == s_reg.req.wdata)
		else $error("write strobe without data");
	rd_release_a: assert property (!data_read_strobe_n_out |-> !ad_oe_out && data_write_strobe_n_out)
		else $error("read strobe with port driven");
	addr_mux_a: assert property ($fell(addr_latch_strobe_out) |-> ad_out == s_reg.req.addr[7:0]
		##1 addr_hi_out == s_reg.req.addr[15:8])
		else $error("address not held on ports");
	upper_addr_a: assert property (s_reg.state != ext_bus_pkg::ST_IDLE |-> addr_hi_out == s_reg.req.addr[15:8])
		else $error("upper address wrong");
	reset_hold_a: assert property (rst_pin_s [*8] |=> core_reset_out)
		else $error("reset not entered after two machine cycles");
	data_len_a: assert property (data_end_s |-> slen_reg == 6'h6 + 6'({s_reg.stretch, 2'b00}))
		else $error("data strobe length wrong");
	mcyc_step_a: assert property (s_reg.phase == 2'h3 |=> s_reg.phase == 2'h0 ##3 s_reg.phase == 2'h3)
		else $error("machine cycle not four clocks");

endmodule

`default_nettype wire

// ### verif/ext_mem_model.sv
// external address latch, program store and data store on the bus pins
// assumes active-low strobes and a transparent latch on the shared port
`timescale 1ns/100ps
`default_nettype none

module ext_mem_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] ad_out_in,
	input  wire logic       ad_oe_in,
	input  wire logic [7:0] addr_hi_in,
	input  wire logic       ale_in,
	input  wire logic       fetch_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       wr_n_in,
	input  wire logic [4:0] delay_in,
	output logic      [7:0] bus_out
);
	logic [7:0] lo_reg;
	logic [7:0] drv_reg;
	logic [4:0] cnt_reg;
	logic [7:0] ram [0:255];

	// ----------------------------------------------------------------
	// latch, stores and port drive
	// ----------------------------------------------------------------
	initial begin
		drv_reg = 8'h00;
		cnt_reg = 5'h00;
	end

	always_latch begin
		if (ale_in)
			lo_reg = ad_out_in;
	end

	// delay_in makes a slow memory; a released port toggles so stale data never passes
	always @(posedge clk_in) begin
		if (!fetch_n_in || !rd_n_in) begin
			if (cnt_reg != 5'h1f)
				cnt_reg <= cnt_reg + 5'h01;
			if (cnt_reg >= delay_in)
				drv_reg <= !fetch_n_in ? (lo_reg ^ addr_hi_in ^ 8'h5a) : ram[lo_reg];
			else
				drv_reg <= ~drv_reg;
		end else begin
			cnt_reg <= 5'h00;
			drv_reg <= ~drv_reg;
		end
		if (!wr_n_in)
			ram[lo_reg] <= ad_out_in;
	end

	assign bus_out = ad_oe_in ? ad_out_in : drv_reg;
endmodule

`default_nettype wire

// ### verif/external_memory_bus_interface_bench.sv
// self-checking bench for the external memory bus interface
// assumes the memory model on the pins and the core side driven by tasks
`timescale 1ns/100ps
`default_nettype none

module external_memory_bus_interface_bench;
	logic               mclk_in;
	logic               rstn_in;
	ext_bus_pkg::req_t  req_in;
	logic               req_valid_in;
	logic [2:0]         stretch_in;
	logic               wait_enable_in;
	logic               fsel_n;
	logic               reset_pin_in;
	logic               wait_pin_in;
	logic [4:0]         delay;
	logic [7:0]         ad_bus;
	logic               req_ready_out;
	logic               rsp_valid_out;
	logic               rsp_external_out;
	logic [7:0]         rsp_rdata_out;
	logic               core_reset_out;
	logic [7:0]         ad_out;
	logic               ad_oe_out;
	logic [7:0]         addr_hi_out;
	logic               ale;
	logic               fetch_n;
	logic               wr_n;
	logic               rd_n;
	int                 fail_count;
	int                 comparisons;
	int                 lat;
	int                 cnt [4];

	ext_bus_if i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req_in), .req_valid_in(req_valid_in),
		.stretch_in(stretch_in), .wait_enable_in(wait_enable_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_external_out(rsp_external_out), .rsp_rdata_out(rsp_rdata_out),
		.core_reset_out(core_reset_out), .external_fetch_select_n_in(fsel_n), .reset_pin_in(reset_pin_in),
		.wait_pin_in(wait_pin_in), .ad_in(ad_bus), .ad_out(ad_out), .ad_oe_out(ad_oe_out),
		.addr_hi_out(addr_hi_out), .addr_latch_strobe_out(ale), .program_fetch_strobe_n_out(fetch_n),
		.data_write_strobe_n_out(wr_n), .data_read_strobe_n_out(rd_n));

	ext_mem_model i_mem (.clk_in(mclk_in), .ad_out_in(ad_out), .ad_oe_in(ad_oe_out), .addr_hi_in(addr_hi_out),
		.ale_in(ale), .fetch_n_in(fetch_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .delay_in(delay), .bus_out(ad_bus));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// request held until the edge that sees ready, then bus activity counted per cycle
	task automatic access(input ext_bus_pkg::access_kind_t k, input logic [15:0] a, input logic [7:0] wd,
		input logic [2:0] st);
		int n;
		n = 0;
		@(posedge mclk_in);
		req_in <= '{kind: k, addr: a, wdata: wd};
		stretch_in <= st;
		req_valid_in <= 1'b1;
		do begin
			@(negedge mclk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 40);
		check(n < 40, "request never taken");
		@(posedge mclk_in);
		req_valid_in <= 1'b0;
		lat = 0;
		cnt = '{default: 0};
		while (lat < 90) begin
			@(negedge mclk_in);
			if (rsp_valid_out === 1'b1)
				break;
			lat++;
			if (ale === 1'b1) begin
				cnt[0]++;
				check(ad_oe_out === 1'b1 && ad_out === a[7:0] && addr_hi_out === a[15:8], "address phase");
			end
			cnt[1] += (fetch_n === 1'b0);
			cnt[2] += (rd_n === 1'b0);
			if (wr_n === 1'b0) begin
				cnt[3]++;
				check(ad_oe_out === 1'b1 && ad_out === wd, "write data on port");
			end
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic ext_check(input ext_bus_pkg::access_kind_t k, input logic [15:0] a, input logic [7:0] wd,
		input logic [2:0] st, input logic [7:0] exp);
		int s;
		s = (k == ext_bus_pkg::ACC_DATA_READ) ? 2 : (k == ext_bus_pkg::ACC_DATA_WRITE) ? 3 : 1;
		access(k, a, wd, st);
		check(lat == 8 + 4 * st && rsp_external_out === 1'b1, "external latency");
		check(cnt[0] == 1 && cnt[s] == 6 + 4 * st && cnt[1] + cnt[2] + cnt[3] == cnt[s], "strobes");
		check(rsp_rdata_out === exp, "returned byte");
	endtask

	task automatic int_fetch(input logic [15:0] a);
		access(ext_bus_pkg::ACC_FETCH, a, 8'h00, 3'h0);
		check(lat <= 1 && rsp_external_out === 1'b0 && cnt[0] + cnt[1] == 0, "internal fetch off bus");
		repeat (4) begin
			check(fetch_n === 1'b1 && ale === 1'b0 && ad_oe_out === 1'b0, "internal fetch quiet");
			@(negedge mclk_in);
		end
	endtask

	task automatic wait_check(input logic en);
		@(posedge mclk_in);
		wait_enable_in <= en;
		wait_pin_in <= 1'b1;
		fork
			access(ext_bus_pkg::ACC_DATA_READ, 16'h2030, 8'h00, 3'h0);
			begin
				repeat (14) @(posedge mclk_in);
				wait_pin_in <= 1'b0;
			end
		join
		check(en ? (lat > 8 && lat <= 24 && lat % 4 == 0) : lat == 8, "wait extension");
		check(rsp_rdata_out === 8'h96 && cnt[2] == lat - 2, "stretched read");
		wait_enable_in <= 1'b0;
	endtask

	task automatic pin_reset(input int len, input logic exp);
		logic seen;
		logic bad;
		seen = 1'b0;
		bad = 1'b0;
		@(posedge mclk_in);
		reset_pin_in <= 1'b1;
		fork
			begin
				repeat (len) @(posedge mclk_in);
				reset_pin_in <= 1'b0;
			end
			repeat (len + 10) begin
				@(negedge mclk_in);
				seen |= (core_reset_out === 1'b1);
				bad |= (core_reset_out === 1'b1 && req_ready_out !== 1'b0);
			end
		join
		check(seen === exp && !bad && core_reset_out === 1'b0, "reset pin");
	endtask

	// ----------------------------------------------------------------
	// clock, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	initial begin
		fail_count = 0;
		comparisons = 0;
		rstn_in = 1'b0;
		req_in = '0;
		req_valid_in = 1'b0;
		stretch_in = 3'h0;
		wait_enable_in = 1'b0;
		fsel_n = 1'b1;
		reset_pin_in = 1'b0;
		wait_pin_in = 1'b0;
		delay = 5'h00;
		repeat (6) @(posedge mclk_in);
		rstn_in <= 1'b1;
		// the pin synchronisers start from zero, so let them fill before the first take
		repeat (8) @(posedge mclk_in);
		int_fetch(16'h0000);
		int_fetch(16'h7fff);
		ext_check(ext_bus_pkg::ACC_FETCH, 16'h8000, 8'h00, 3'h0, 8'hda);
		ext_check(ext_bus_pkg::ACC_CODE_TABLE, 16'hc3a5, 8'h00, 3'h0, 8'h3c);
		@(posedge mclk_in);
		fsel_n <= 1'b0;
		repeat (6) @(posedge mclk_in);
		ext_check(ext_bus_pkg::ACC_FETCH, 16'h0012, 8'h00, 3'h0, 8'h48);
		@(posedge mclk_in);
		fsel_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_in);
			delay <= 5'(3 * i);
			ext_check(ext_bus_pkg::ACC_DATA_WRITE, {8'h20 + 8'(i), 8'h30 + 8'(i)}, 8'h96 ^ 8'(i), 3'(i), 8'h00);
			ext_check(ext_bus_pkg::ACC_DATA_READ, {8'h20 + 8'(i), 8'h30 + 8'(i)}, 8'h00, 3'(i), 8'h96 ^ 8'(i));
		end
		@(posedge mclk_in);
		delay <= 5'h00;
		wait_check(1'b0);
		wait_check(1'b1);
		pin_reset(7, 1'b0);
		pin_reset(10, 1'b1);
		ext_check(ext_bus_pkg::ACC_DATA_READ, 16'h2131, 8'h00, 3'h0, 8'h97);
		give_verdict;
	end

	initial begin
		#100us;
		fail_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		give_verdict;
	end
endmodule

`default_nettype wire
